// ### verilog/dsp_params.svh
// Purpose: Constants for the dual serial port
// Assumes: 100 MHz system clock
// Notes:   Counts and field codes only
`ifndef DSP_PARAMS_SVH
`define DSP_PARAMS_SVH
`define DSP_CLK_MHZ      100
`define DSP_RX_DEPTH     4
`define DSP_TX_DEPTH     2
`define DSP_OVS          16
`define DSP_STOP_MAX     32
`define DSP_PRESC_RST    16'h0035
`define DSP_STOP_RST     6'h10
`endif

// ### verilog/dsp_pkg.sv
// Purpose: Types for the dual serial port
// Assumes: Nothing
// Notes:   Mode and parity encodings
package dsp_pkg;
    typedef enum logic [1:0] {DSP_PAR_NONE, DSP_PAR_EVEN, DSP_PAR_ODD} dsp_par_t;
    typedef enum logic [1:0] {DSP_MODE_NORMAL, DSP_MODE_ECHO, DSP_MODE_LOCAL,
                              DSP_MODE_REMOTE} dsp_mode_t;
endpackage

// ### verilog/dsp_fifo.sv
// Purpose: Small character queue with registered read data
// Assumes: Push ignored when full, pop ignored when empty
// Notes:   Depth is a power of two
`timescale 1ns/1ps
module dsp_fifo #(parameter int DEPTH = 4, parameter int AW = 2)
(
    input  wire logic         clock,
    input  wire logic         rst_b,
    input  wire logic         push,
    input  wire logic [10:0]  wdata,
    input  wire logic         pop,
    output logic [10:0]       rdata,
    output logic              empty,
    output logic              full
);
    logic [10:0]  mem_ff [DEPTH];
    logic [AW:0]  wp_ff;
    logic [AW:0]  rp_ff;
    wire          do_push = push & ~full;
    wire          do_pop  = pop & ~empty;
    // Head after this edge; a push into the slot that becomes head bypasses memory
    wire [AW-1:0] rp_nxt  = rp_ff[AW-1:0] + AW'(do_pop);
    wire          wr_head = do_push && (wp_ff[AW-1:0] == rp_nxt);
    wire [AW:0]   fill    = wp_ff - rp_ff;
    assign empty = (wp_ff == rp_ff);
    assign full  = (wp_ff[AW] != rp_ff[AW]) && (wp_ff[AW-1:0] == rp_ff[AW-1:0]);
    // Pointers carry a wrap bit so full and empty are honest
    always_ff @(posedge clock or negedge rst_b)
    begin
        if (!rst_b)
        begin
            wp_ff <= '0;
            rp_ff <= '0;
        end
        else
        begin
            if (do_push) wp_ff <= wp_ff + 1'b1;
            if (do_pop)  rp_ff <= rp_ff + 1'b1;
        end
    end
    // Storage plus registered head word
    always_ff @(posedge clock)
    begin
        if (do_push) mem_ff[wp_ff[AW-1:0]] <= wdata;
    end
    always_ff @(posedge clock or negedge rst_b)
    begin
        if (!rst_b) rdata <= '0;
        else        rdata <= wr_head ? wdata : mem_ff[rp_nxt];
    end
    // Pointer arithmetic never claims more words than the depth
    property p_fill;
        @(posedge clock) disable iff (!rst_b)
        fill <= DEPTH;
    endproperty
    a_fill: assert property (p_fill)
        else $error("queue fill beyond depth");
endmodule // dsp_fifo

// ### verilog/dsp_channel.sv
// Purpose: One full-duplex asynchronous serial channel
// Assumes: Inputs synchronous to clock; rx line already synchronised
// Notes:   Two instances make the dual port
// Function
// - Two channels exist, each with independent receive and transmit paths running at once.
// - Data length is five to eight bits, set identically at both ends.
// - Parity is even, odd or none, generated on transmit and checked on receive.
// - Stop interval is programmable up to two bits in sixteenth-bit steps.
// - The receiver queues up to four characters for software.
// - The transmitter queues up to two characters from software.
// - Receive errors set readable sticky flags and each interrupt source has a mask.
// - Each channel has a request-to-send output and a clear-to-send input from the far end.
// - Bit timing comes from the system clock through a programmable prescaler.
// - Modes normal, auto echo, local loopback and remote loopback are selectable.
// - An interrupt is raised for receive data, transmit space and errors, subject to masks.
// - Each channel issues DMA requests for receive and transmit.
`timescale 1ns/1ps
`include "dsp_params.svh"
module dsp_channel
(
    input  wire logic             clock,
    input  wire logic             rst_b,
    input  wire logic [15:0]      prescale,
    input  wire logic [1:0]       data_bits,
    input  wire dsp_pkg::dsp_par_t parity,
    input  wire logic [5:0]       stop_len,
    input  wire dsp_pkg::dsp_mode_t mode,
    input  wire logic [3:0]       irq_mask,
    input  wire logic             tx_wr,
    input  wire logic [7:0]       tx_data,
    input  wire logic             rx_rd,
    output logic [7:0]            rx_data,
    output logic                  rx_valid,
    input  wire logic             err_clr,
    output logic [2:0]            err_flags,
    output logic                  tx_ready,
    output logic                  irq,
    output logic                  dma_rx_req,
    output logic                  dma_tx_req,
    input  wire logic             rxd,
    output logic                  txd,
    input  wire logic             cts_b,
    output logic                  rts_b
);
    import dsp_pkg::*;
    typedef enum {DSP_TX_IDLE, DSP_TX_START, DSP_TX_DATA, DSP_TX_PAR, DSP_TX_STOP} dsp_txs_t;
    typedef enum {DSP_RX_IDLE, DSP_RX_START, DSP_RX_DATA, DSP_RX_PAR, DSP_RX_STOP} dsp_rxs_t;

    // Prescaler gives a 16x oversample tick
    logic [15:0] pre_ff;
    wire         tick = (pre_ff == 16'h0000);
    always_ff @(posedge clock or negedge rst_b)
    begin
        if (!rst_b) pre_ff <= '0;
        else        pre_ff <= tick ? prescale : pre_ff - 16'h0001;
    end

    wire [3:0] nbits  = 4'h5 + {2'b00, data_bits};
    wire       par_on = (parity != DSP_PAR_NONE);
    // Longer settings clamp to two bit times, the most the frame allows
    wire [5:0] stop_eff = (stop_len > 6'(`DSP_STOP_MAX)) ? 6'(`DSP_STOP_MAX) : stop_len;

    // Transmit queue, two deep
    logic [10:0] tq_rd;
    logic        tq_empty;
    logic        tq_full;
    logic        tq_pop;
    logic        rmt_push;
    logic [7:0]  rx_shift_ff;
    wire         tq_push = (mode == DSP_MODE_REMOTE) ? rmt_push : tx_wr;
    wire [7:0]   tq_wd   = (mode == DSP_MODE_REMOTE) ? rx_shift_ff : tx_data;
    dsp_fifo #(.DEPTH(`DSP_TX_DEPTH), .AW(1)) u_txq
    (
        .clock (clock), .rst_b (rst_b), .push (tq_push), .wdata ({3'b000, tq_wd}),
        .pop (tq_pop), .rdata (tq_rd), .empty (tq_empty), .full (tq_full)
    );
    assign tx_ready   = ~tq_full & (mode != DSP_MODE_REMOTE);
    assign dma_tx_req = tx_ready;

    // Transmitter, independent of the receiver
    dsp_txs_t    txs_ff;
    logic [3:0]  tsub_ff;
    logic [5:0]  tcnt_ff;
    logic [7:0]  tsh_ff;
    logic        tpar_ff;
    logic        tline_ff;
    logic        fetch_ff;
    // Flow control: hold start while far end is not clear
    wire tx_go = ~tq_empty & ~cts_b & ~fetch_ff;
    assign tq_pop = (txs_ff == DSP_TX_IDLE) & tx_go;
    wire tbit_end = tick & (tsub_ff == 4'hf);
    always_ff @(posedge clock or negedge rst_b)
    begin
        if (!rst_b)
        begin
            txs_ff <= DSP_TX_IDLE; tsub_ff <= '0; tcnt_ff <= '0; tsh_ff <= '0;
            tpar_ff <= 1'b0; tline_ff <= 1'b1; fetch_ff <= 1'b0;
        end
        else
        begin
            fetch_ff <= tq_pop;
            if (tick) tsub_ff <= tsub_ff + 4'h1;
            unique case (txs_ff)
                DSP_TX_IDLE:
                begin
                    tline_ff <= 1'b1;
                    // Head word is registered, so it is taken at the pop itself
                    if (tq_pop) tsh_ff <= tq_rd[7:0];
                    if (fetch_ff)
                    begin
                        tpar_ff <= (parity == DSP_PAR_ODD);
                        tsub_ff <= '0; txs_ff <= DSP_TX_START; tline_ff <= 1'b0;
                    end
                end
                DSP_TX_START:
                    if (tbit_end)
                    begin
                        txs_ff <= DSP_TX_DATA; tcnt_ff <= '0; tline_ff <= tsh_ff[0];
                    end
                DSP_TX_DATA:
                    if (tbit_end)
                    begin
                        tpar_ff <= tpar_ff ^ tsh_ff[0];
                        tsh_ff  <= {1'b0, tsh_ff[7:1]};
                        tcnt_ff <= tcnt_ff + 6'h01;
                        if (tcnt_ff[3:0] == nbits - 4'h1)
                        begin
                            txs_ff <= par_on ? DSP_TX_PAR : DSP_TX_STOP;
                            tline_ff <= par_on ? (tpar_ff ^ tsh_ff[0]) : 1'b1;
                            tcnt_ff <= '0;
                        end
                        else tline_ff <= tsh_ff[1];
                    end
                DSP_TX_PAR:
                    if (tbit_end)
                    begin
                        txs_ff <= DSP_TX_STOP; tline_ff <= 1'b1; tcnt_ff <= '0;
                    end
                DSP_TX_STOP:
                    // Stop length counted in sixteenths
                    if (tick)
                    begin
                        tcnt_ff <= tcnt_ff + 6'h01;
                        if (tcnt_ff + 6'h01 >= stop_eff) txs_ff <= DSP_TX_IDLE;
                    end
            endcase
        end
    end

    // Transmitter checks
    property p_cts_hold;
        @(posedge clock) disable iff (!rst_b)
        (txs_ff == DSP_TX_IDLE && cts_b && !fetch_ff) |=> (txs_ff == DSP_TX_IDLE);
    endproperty
    a_cts_hold: assert property (p_cts_hold)
        else $error("frame started while far end not clear");
    property p_stop_max;
        @(posedge clock) disable iff (!rst_b)
        (txs_ff == DSP_TX_STOP) |-> (tcnt_ff < `DSP_STOP_MAX);
    endproperty
    a_stop_max: assert property (p_stop_max)
        else $error("stop interval beyond two bit times");
    property p_tx_count;
        @(posedge clock) disable iff (!rst_b)
        (txs_ff == DSP_TX_DATA) |-> (tcnt_ff[3:0] < nbits);
    endproperty
    a_tx_count: assert property (p_tx_count)
        else $error("transmit data count beyond length");

    // Receiver input and transmit line routing by mode
    wire rx_in = (mode == DSP_MODE_LOCAL) ? tline_ff : rxd;
    assign txd = (mode == DSP_MODE_ECHO) ? rxd :
                 (mode == DSP_MODE_LOCAL) ? 1'b1 : tline_ff;
    property p_txd_idle;
        @(posedge clock) disable iff (!rst_b)
        (txs_ff == DSP_TX_IDLE && mode != DSP_MODE_ECHO) |-> txd;
    endproperty
    a_txd_idle: assert property (p_txd_idle)
        else $error("transmit line low between frames");

    dsp_rxs_t   rxs_ff;
    logic [3:0] rsub_ff;
    logic [3:0] rcnt_ff;
    logic       rpar_ff;
    logic       perr_ff;
    logic       rdone_ff;
    logic       ferr_ff;
    wire        rsamp = tick & (rsub_ff == 4'h7);
    logic       rprev_ff;
    // Start needs a falling edge: a low stop bit must not restart the receiver
    always_ff @(posedge clock or negedge rst_b)
    begin
        if (!rst_b) rprev_ff <= 1'b1;                 // Idle level, no false edge
        else        rprev_ff <= rx_in;
    end
    wire        rx_fall = rprev_ff & ~rx_in;
    always_ff @(posedge clock or negedge rst_b)
    begin
        if (!rst_b)
        begin
            rxs_ff <= DSP_RX_IDLE; rsub_ff <= '0; rcnt_ff <= '0; rx_shift_ff <= '0;
            rpar_ff <= 1'b0; perr_ff <= 1'b0; rdone_ff <= 1'b0; ferr_ff <= 1'b0;
        end
        else
        begin
            rdone_ff <= 1'b0;
            if (tick) rsub_ff <= rsub_ff + 4'h1;
            unique case (rxs_ff)
                DSP_RX_IDLE:
                    if (rx_fall)
                    begin
                        rxs_ff <= DSP_RX_START; rsub_ff <= '0;
                    end
                DSP_RX_START:
                    if (rsamp)
                    begin
                        rxs_ff <= rx_in ? DSP_RX_IDLE : DSP_RX_DATA;
                        rcnt_ff <= '0; rx_shift_ff <= '0;
                        rpar_ff <= (parity == DSP_PAR_ODD);
                    end
                DSP_RX_DATA:
                    if (rsamp)
                    begin
                        rx_shift_ff[rcnt_ff[2:0]] <= rx_in;
                        rpar_ff <= rpar_ff ^ rx_in;
                        rcnt_ff <= rcnt_ff + 4'h1;
                        if (rcnt_ff == nbits - 4'h1) rxs_ff <= par_on ? DSP_RX_PAR : DSP_RX_STOP;
                    end
                DSP_RX_PAR:
                    if (rsamp)
                    begin
                        perr_ff <= rx_in != rpar_ff;
                        rxs_ff <= DSP_RX_STOP;
                    end
                DSP_RX_STOP:
                    if (rsamp)
                    begin
                        ferr_ff <= ~rx_in; rdone_ff <= 1'b1; rxs_ff <= DSP_RX_IDLE;
                        if (!par_on) perr_ff <= 1'b0;
                    end
            endcase
        end
    end

    property p_rx_count;
        @(posedge clock) disable iff (!rst_b)
        (rxs_ff == DSP_RX_DATA) |-> (rcnt_ff < nbits);
    endproperty
    a_rx_count: assert property (p_rx_count)
        else $error("receive data count beyond length");

    // Receive queue, four deep
    logic [10:0] rq_rd;
    logic        rq_empty;
    logic        rq_full;
    wire         to_sw   = rdone_ff & (mode != DSP_MODE_REMOTE);
    assign       rmt_push = rdone_ff & (mode == DSP_MODE_REMOTE);
    dsp_fifo #(.DEPTH(`DSP_RX_DEPTH), .AW(2)) u_rxq
    (
        .clock (clock), .rst_b (rst_b), .push (to_sw),
        .wdata ({1'b0, ferr_ff, perr_ff, rx_shift_ff}),
        .pop (rx_rd), .rdata (rq_rd), .empty (rq_empty), .full (rq_full)
    );
    assign rx_data    = rq_rd[7:0];
    assign rx_valid   = ~rq_empty;
    assign dma_rx_req = rx_valid;
    assign rts_b      = rq_full;                        // Ask far end to pause

    // Sticky errors: set wins over clear
    logic [2:0] err_ff;
    wire  [2:0] err_set = {to_sw & rq_full, to_sw & ferr_ff, to_sw & perr_ff & par_on};
    always_ff @(posedge clock or negedge rst_b)
    begin
        if (!rst_b) err_ff <= '0;
        else        err_ff <= err_set | (err_clr ? 3'b000 : err_ff);
    end
    assign err_flags = err_ff;
    property p_err_sticky;
        @(posedge clock) disable iff (!rst_b)
        !err_clr |=> ((err_ff & $past(err_ff)) == $past(err_ff));
    endproperty
    a_err_sticky: assert property (p_err_sticky)
        else $error("error flag dropped without clear");
    // Main scenarios worth seeing
    c_par_err: cover property (@(posedge clock) disable iff (!rst_b) err_set[0]);
    c_overrun: cover property (@(posedge clock) disable iff (!rst_b) err_set[2]);
    c_remote_push: cover property (@(posedge clock) disable iff (!rst_b) rmt_push);
    c_cts_wait: cover property (@(posedge clock) disable iff (!rst_b) cts_b & ~tq_empty);
    // Masked interrupt sources
    assign irq = |({|err_ff, rq_full, rx_valid, tx_ready} & irq_mask);
endmodule // dsp_channel

// ### dv/dsp_remote.sv
// Purpose: Remote serial device facing one channel
// Assumes: BT_NS equals one bit time of the channel
// Notes:   Sends by task, receives in a free process
`timescale 1ns/1ps
module dsp_remote
import dsp_pkg::*;
#(parameter int BT_NS = 320)
(
    input  wire logic       txd,
    input  wire logic [3:0] nbits,
    input  wire dsp_par_t   par,
    output logic            rxd,
    output logic            cts_b
);
    logic [7:0] got;
    logic       gpar;
    logic       gstop;
    int         gcnt;
    realtime    gt;
    // Idle line high, clear until set_cts; rts ignored so overrun can be forced
    initial
    begin
        rxd = 1'b1;
        cts_b = 1'b0;
        gcnt = 0;
    end
    // One frame LSB first; bad_par and bad_stop break it on purpose
    task automatic send(input logic [7:0] d, input logic bad_par, input logic bad_stop);
        logic p;
        p = ^(d & ((8'h01 << nbits) - 8'h01)) ^ (par == DSP_PAR_ODD) ^ bad_par;
        rxd = 1'b0;
        #(BT_NS);
        for (int i = 0; i < nbits; i++)
        begin
            rxd = d[i];
            #(BT_NS);
        end
        if (par != DSP_PAR_NONE)
        begin
            rxd = p;
            #(BT_NS);
        end
        rxd = ~bad_stop;
        #(BT_NS);
        rxd = 1'b1;
        #(BT_NS);
    endtask
    // Far end readiness, low means clear to send
    task automatic set_cts(input logic busy);
        cts_b = busy;
    endtask
    // Mid-bit sampling of whatever the channel sends
    always
    begin
        @(negedge txd);
        gt = $realtime;
        #(BT_NS / 2);
        got = 8'h00;
        gpar = 1'b0;
        for (int i = 0; i < nbits; i++)
        begin
            #(BT_NS);
            got[i] = txd;
        end
        if (par != DSP_PAR_NONE)
        begin
            #(BT_NS);
            gpar = txd;
        end
        #(BT_NS);
        gstop = txd;
        gcnt++;
    end
endmodule // dsp_remote

// ### dv/dsp_channel_tb.sv
// Purpose: Self-checking bench for one serial channel
// Assumes: Prescale 1, so a bit is 32 clocks
// Notes:   Inputs move 1 ns after the rising edge
`timescale 1ns/1ps
`include "dsp_params.svh"
module dsp_channel_tb;
    import dsp_pkg::*;
    localparam int BT = 320;
    logic       clock = 1'b0, rst_b = 1'b0, tx_wr = 1'b0, rx_rd = 1'b0, err_clr = 1'b0;
    logic [15:0] prescale = 16'h0001;
    logic [1:0] data_bits = 2'h3;
    logic [5:0] stop_len = 6'h10;
    logic [3:0] irq_mask = 4'h0;
    logic [7:0] tx_data = 8'h00, rx_data;
    dsp_par_t   parity = DSP_PAR_NONE;
    dsp_mode_t  mode = DSP_MODE_NORMAL;
    logic       rx_valid, tx_ready, irq, dma_rx_req, dma_tx_req, rxd, txd, cts_b, rts_b;
    logic [2:0] err_flags;
    int         fails = 0, checks_done = 0;
    dsp_channel dsp_channel_inst (.clock(clock), .rst_b(rst_b), .prescale(prescale),
        .data_bits(data_bits), .parity(parity), .stop_len(stop_len), .mode(mode),
        .irq_mask(irq_mask), .tx_wr(tx_wr), .tx_data(tx_data), .rx_rd(rx_rd),
        .rx_data(rx_data), .rx_valid(rx_valid), .err_clr(err_clr), .err_flags(err_flags),
        .tx_ready(tx_ready), .irq(irq), .dma_rx_req(dma_rx_req), .dma_tx_req(dma_tx_req),
        .rxd(rxd), .txd(txd), .cts_b(cts_b), .rts_b(rts_b));
    dsp_remote #(.BT_NS(BT)) dsp_remote_inst (.txd(txd), .nbits({2'h0, data_bits} + 4'h5),
        .par(parity), .rxd(rxd), .cts_b(cts_b));
    // Free-running 100 MHz clock
    initial
    begin
        forever #5 clock = ~clock;
    end
    task automatic tick();
        @(posedge clock);
        #1;
    endtask
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string m);
        checks_done++;
        if (seen !== exp)
        begin
            fails++;
            $display("BAD %0t %s seen %h want %h", $realtime, m, seen, exp);
        end
    endtask
    task automatic results();
        $display("checks %0d fails %0d", checks_done, fails);
        if (fails == 0 && checks_done > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    // Bounded wait: n0 < 0 waits for rx data, else for a new frame seen remotely
    task automatic hold(input int n0);
        int k;
        k = 0;
        while ((n0 < 0 ? rx_valid !== 1'b1 : dsp_remote_inst.gcnt <= n0) && k < 20000)
        begin
            tick();
            k++;
        end
        if (k == 20000)
        begin
            fails++;
            $display("BAD %0t wait ran out", $realtime);
            results();
        end
    endtask
    task automatic pulse_rd();
        rx_rd = 1'b1;
        tick();
        rx_rd = 1'b0;
        tick();
    endtask
    task automatic rd(input logic [7:0] e);
        hold(-1);
        chk(rx_data, e, "rx data");
        pulse_rd();
    endtask
    task automatic clean();
        repeat (6) if (rx_valid === 1'b1) pulse_rd();
        err_clr = 1'b1;
        tick();
        err_clr = 1'b0;
        tick();
        chk(err_flags, 3'h0, "flags clear");
    endtask
    task automatic t_reset();
        irq_mask = 4'h1;
        tick();
        chk({txd, rts_b, rx_valid, tx_ready, dma_rx_req, dma_tx_req}, 6'h25, "idle pins");
        chk(irq, 1'b1, "tx space irq");
        irq_mask = 4'h0;
        tick();
        chk(irq, 1'b0, "masked");
        $display("test reset done");
    endtask
    // Every length and parity, both directions at once
    task automatic t_formats();
        logic [7:0] m, tv, rv;
        int n0;
        for (int b = 0; b < 4; b++)
            for (int p = 0; p < 3; p++)
            begin
                data_bits = b[1:0];
                parity = dsp_par_t'(p);
                m = (8'h01 << (b + 5)) - 8'h01;
                tv = 8'h96 ^ 8'(b * 3 + p);
                rv = 8'h3c + 8'(b * 5 + p);
                tick();
                n0 = dsp_remote_inst.gcnt;
                tx_data = tv;
                tx_wr = 1'b1;
                tick();
                tx_wr = 1'b0;
                dsp_remote_inst.send(rv, 1'b0, 1'b0);
                hold(n0);
                chk(dsp_remote_inst.got, tv & m, "tx data");
                chk(dsp_remote_inst.gpar, p == 0 ? 1'b0 : ^(tv & m) ^ (p == 2), "par");
                chk(err_flags, 3'h0, "no error");
                rd(rv & m);
            end
        $display("test formats done");
    endtask
    // Back-to-back queue, 1.5 stop bits between frames
    task automatic t_stop();
        realtime t0;
        int n0;
        data_bits = 2'h3;
        parity = DSP_PAR_NONE;
        stop_len = 6'h18;
        n0 = dsp_remote_inst.gcnt;
        tx_data = 8'h11;
        tx_wr = 1'b1;
        tick();
        chk(tx_ready, 1'b1, "queue space");
        tx_data = 8'h22;
        tick();
        tx_wr = 1'b0;
        hold(n0);
        t0 = dsp_remote_inst.gt;
        chk(dsp_remote_inst.got, 8'h11, "first");
        hold(n0 + 1);
        chk(dsp_remote_inst.got, 8'h22, "second");
        t0 = dsp_remote_inst.gt - t0 - (9 * BT + 24 * BT / 16);
        chk(t0 > -40 && t0 < 40, 1'b1, "stop length");
        stop_len = 6'h10;
        // Far end not clear: the queued character must wait
        dsp_remote_inst.set_cts(1'b1);
        n0 = dsp_remote_inst.gcnt;
        tx_data = 8'h5a;
        tx_wr = 1'b1;
        tick();
        tx_wr = 1'b0;
        repeat (100) tick();
        chk({dsp_remote_inst.gcnt == n0, txd}, 2'h3, "held by cts");
        dsp_remote_inst.set_cts(1'b0);
        hold(n0);
        chk(dsp_remote_inst.got, 8'h5a, "after cts");
        $display("test stop done");
    endtask
    task automatic t_fifo();
        irq_mask = 4'h2;
        for (int i = 0; i <= `DSP_RX_DEPTH; i++)
            dsp_remote_inst.send(8'h30 + 8'(i), 1'b0, 1'b0);
        tick();
        chk({rts_b, irq, dma_rx_req, err_flags}, 6'h3c, "full");
        irq_mask = 4'h4;
        tick();
        chk(irq, 1'b1, "full irq");
        for (int i = 0; i < `DSP_RX_DEPTH; i++)
            rd(8'h30 + 8'(i));
        chk({rts_b, irq, dma_rx_req, rx_valid}, 4'h0, "drained");
        irq_mask = 4'h0;
        clean();
        $display("test fifo done");
    endtask
    task automatic t_errors();
        parity = DSP_PAR_EVEN;
        dsp_remote_inst.send(8'h0f, 1'b1, 1'b0);
        irq_mask = 4'h8;
        tick();
        chk({irq, err_flags}, 4'h9, "parity error");
        clean();
        dsp_remote_inst.send(8'h0f, 1'b0, 1'b1);
        tick();
        chk(err_flags[1], 1'b1, "framing error");
        irq_mask = 4'h0;
        clean();
        parity = DSP_PAR_NONE;
        $display("test errors done");
    endtask
    task automatic t_modes();
        int n0;
        mode = DSP_MODE_ECHO;
        n0 = dsp_remote_inst.gcnt;
        dsp_remote_inst.send(8'h6c, 1'b0, 1'b0);
        hold(n0);
        chk(dsp_remote_inst.got, 8'h6c, "echo");
        clean();
        mode = DSP_MODE_REMOTE;
        n0 = dsp_remote_inst.gcnt;
        dsp_remote_inst.send(8'h93, 1'b0, 1'b0);
        hold(n0);
        chk(dsp_remote_inst.got, 8'h93, "remote back");
        repeat (40) tick();
        chk({rx_valid, txd, tx_ready, dma_tx_req}, 4'h4, "remote hidden");
        mode = DSP_MODE_LOCAL;
        n0 = dsp_remote_inst.gcnt;
        tick();
        tx_data = 8'h4e;
        tx_wr = 1'b1;
        tick();
        tx_wr = 1'b0;
        rd(8'h4e);
        chk(dsp_remote_inst.gcnt, n0, "line quiet");
        mode = DSP_MODE_NORMAL;
        $display("test modes done");
    endtask
    // Reset held three cycles, then the scenarios in turn
    initial
    begin
        repeat (3) @(posedge clock);
        #1;
        rst_b = 1'b1;
        tick();
        t_reset();
        t_formats();
        t_stop();
        t_fifo();
        t_errors();
        t_modes();
        results();
    end
endmodule // dsp_channel_tb
